/* shared/sic_code_if.sv */
`timescale 1ns/1ps
// request and lamp output of the two-digit code flasher
interface sic_code_if;
    logic [7:0] code;   // two hex digits to flash
    logic run;          // flashing enabled
    logic lamp;         // flash pattern
    logic tick;         // half-period tick from the main file
    modport owner (output code, output run, output tick, input lamp);
    modport flasher (input code, input run, input tick, output lamp);
endinterface

/* shared/sic_pkg.sv */
package sic_pkg;
    // blink timing, in milliseconds, at a 25 MHz clock
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned FAST_HALF_MS = 125;
    localparam int unsigned FLASH_HALF_MS = 250;
    // error-code pauses, in flash half periods
    localparam int unsigned SHORT_PAUSE_HALVES = 4;
    localparam int unsigned LONG_PAUSE_HALVES = 8;
    // traffic pulse stretch, in milliseconds
    localparam int unsigned TRAFFIC_HOLD_MS = 100;
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int unsigned TRAFFIC_HOLD_CYC =
        CLK_HZ / 1000 * TRAFFIC_HOLD_MS;
    // net interface operating states
    typedef enum logic [5:0] {
        SIC_NET_HWFAIL = 6'h01,
        SIC_NET_DIAG = 6'h02,
        SIC_NET_WAITCFG = 6'h04,
        SIC_NET_WAITIP = 6'h08,
        SIC_NET_OPER = 6'h10,
        SIC_NET_LOAD = 6'h20
    } sic_net_state_t;
    // code flasher phases
    typedef enum logic [3:0] {
        SIC_FL_HIGH = 4'h1,
        SIC_FL_GAP = 4'h2,
        SIC_FL_LOW = 4'h4,
        SIC_FL_REST = 4'h8
    } sic_fl_state_t;
endpackage

/* sim/sic_lamp_viewer.sv */
`timescale 1ns/1ps
// watches the lamp row the way an operator would: counts lit cycles,
// counts turn-on events and counts cycles where a lamp disagrees with
// the cpu health lamp or the net health lamp
module sic_lamp_viewer (
    input wire clock,
    input wire clear,
    input wire [11:0] lamps,
    output logic [15:0] onCnt [12],
    output logic [15:0] riseCnt [12],
    output logic [15:0] diffCpu [12],
    output logic [15:0] diffNet [12]
);
    logic [11:0] prevLamps; // lamp row one cycle back

    // clear holds counts at zero and keeps a fresh previous sample, so
    // the first turn-on inside a window is judged against real history
    always @(posedge clock) begin
        prevLamps <= lamps;
        for (int i = 0; i < 12; i++) begin
            if (clear) begin
                onCnt[i] <= 16'h0000;
                riseCnt[i] <= 16'h0000;
                diffCpu[i] <= 16'h0000;
                diffNet[i] <= 16'h0000;
            end else begin
                onCnt[i] <= onCnt[i] + 16'(lamps[i]);
                riseCnt[i] <= riseCnt[i] + 16'(lamps[i] & ~prevLamps[i]);
                diffCpu[i] <= diffCpu[i] + 16'(lamps[i] ^ lamps[0]);
                diffNet[i] <= diffNet[i] + 16'(lamps[i] ^ lamps[5]);
            end
        end
    end
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
// drives operating states, lets the lamps settle, then judges each lamp
// not marked DC over a window that spans whole blink periods
module testbench;
    localparam int unsigned SLOW = 8; // slow half period, cycles
    localparam int unsigned FAST = 4; // fast half period, cycles
    localparam int unsigned FLASH = 6; // code flash half period
    localparam int unsigned HOLD = 10; // traffic stretch, cycles
    localparam int OFF = -1; // lamp dark all window
    localparam int ON = -2; // lamp lit all window
    localparam int DC = -3; // lamp not judged
    localparam int W = 64; // four slow periods, eight fast periods
    logic clock, nrst, clear;
    logic cpuDiagPass, cpuFault, cpuHalt, cpuBoot, cpuRun, outScanEn;
    logic serialPortOneAct, serialPortTwoAct;
    logic netAvailable, netTraffic, eventLogged;
    logic [7:0] cpuFaultCode, netFailCode;
    logic [5:0] netState;
    logic [1:0] portLink, portTraffic, portFast, carrierLamp, speedLamp;
    logic cpuHealthLamp, runLamp, outputs_enabled_lamp;
    logic serial1_activity_lamp, serial2_activity_lamp;
    logic net_health_lamp, net_availability_lamp, netEventLamp;
    logic [11:0] lamps; // index 0 cpu health, 5 net health
    logic [15:0] onCnt [12], riseCnt [12], diffCpu [12], diffNet [12];
    int e [12]; // expected lamp kinds or rise counts
    int miscompares = 0;
    int n_compared = 0;

    assign lamps = {speedLamp, carrierLamp, netEventLamp,
        net_availability_lamp, net_health_lamp, serial2_activity_lamp,
        serial1_activity_lamp, outputs_enabled_lamp, runLamp,
        cpuHealthLamp};

    sic_status_lamps #(.SLOW_HALF(SLOW), .FAST_HALF(FAST),
        .FLASH_HALF(FLASH), .TRAFFIC_HOLD(HOLD), .NPORTS(2)) u_dut (
        .clock(clock), .nrst(nrst), .cpuDiagPass(cpuDiagPass),
        .cpuFault(cpuFault), .cpuFaultCode(cpuFaultCode),
        .cpuHalt(cpuHalt), .cpuBoot(cpuBoot), .cpuRun(cpuRun),
        .outScanEn(outScanEn), .serialPortOneAct(serialPortOneAct),
        .serialPortTwoAct(serialPortTwoAct), .netState(netState),
        .netFailCode(netFailCode), .netAvailable(netAvailable),
        .netTraffic(netTraffic), .eventLogged(eventLogged),
        .portLink(portLink), .portTraffic(portTraffic),
        .portFast(portFast), .cpuHealthLamp(cpuHealthLamp),
        .runLamp(runLamp), .outputs_enabled_lamp(outputs_enabled_lamp),
        .serial1_activity_lamp(serial1_activity_lamp),
        .serial2_activity_lamp(serial2_activity_lamp),
        .net_health_lamp(net_health_lamp),
        .net_availability_lamp(net_availability_lamp),
        .netEventLamp(netEventLamp), .carrierLamp(carrierLamp),
        .speedLamp(speedLamp));

    sic_lamp_viewer u_view (.clock(clock), .clear(clear), .lamps(lamps),
        .onCnt(onCnt), .riseCnt(riseCnt), .diffCpu(diffCpu),
        .diffNet(diffNet));

    // free running 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // one comparison, reported at once on mismatch
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    // settle past sync and traffic stretch, observe w cycles, judge e
    task automatic check(input string name, input int w);
        repeat (24) @(posedge clock);
        clear <= 1'b0;
        repeat (w) @(posedge clock);
        clear <= 1'b1;
        #1;
        for (int i = 0; i < 12; i++) begin
            if (e[i] == OFF) cmp(onCnt[i], 16'h0000);
            else if (e[i] == ON) cmp(onCnt[i], 16'(w));
            else if (e[i] >= 0) cmp(riseCnt[i], 16'(e[i]));
        end
        $display("test %s done", name);
    endtask

    // lamp idx must track the cpu (r=0) or net (r=1) health lamp
    task automatic unison(input int idx, input int r);
        cmp((r == 0) ? diffCpu[idx] : diffNet[idx], 16'h0000);
    endtask

    // one net interface state, judging only the three net lamps
    task automatic net_case(input logic [5:0] st, input int w,
        input int nh, input int av, input int ev);
        @(posedge clock);
        netState <= st;
        e = '{DC, DC, DC, DC, DC, nh, av, ev, DC, DC, DC, DC};
        check($sformatf("net state %h", st), w);
    endtask

    // verdict and end of run
    task automatic results();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("watchdog expired");
        results();
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        clear = 1'b1;
        {cpuFault, cpuHalt, cpuBoot, cpuRun, outScanEn} = 5'h00;
        {serialPortOneAct, serialPortTwoAct, netTraffic} = 3'h0;
        cpuDiagPass = 1'b1;
        cpuFaultCode = 8'h13;
        netFailCode = 8'h23;
        netState = 6'h10;
        netAvailable = 1'b1;
        eventLogged = 1'b0;
        portLink = 2'h3;
        portTraffic = 2'h0;
        portFast = 2'h1;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        cpuRun <= 1'b1;
        outScanEn <= 1'b1;
        e = '{ON, ON, ON, OFF, OFF, ON, ON, ON, ON, ON, ON, OFF};
        check("normal", W);
        @(posedge clock);
        {cpuRun, outScanEn, serialPortOneAct} <= 3'h1;
        {netTraffic, eventLogged} <= 2'h3;
        portLink <= 2'h1;
        portTraffic <= 2'h1;
        portFast <= 2'h3;
        e = '{ON, OFF, OFF, 8, OFF, ON, 8, OFF, 8, OFF, ON, OFF};
        check("traffic", W);
        @(posedge clock);
        {serialPortOneAct, serialPortTwoAct} <= 2'h1;
        {netAvailable, netTraffic} <= 2'h0;
        e = '{ON, OFF, OFF, OFF, 8, ON, OFF, OFF, DC, DC, DC, DC};
        check("serial two", W);
        @(posedge clock);
        {cpuHalt, cpuRun, outScanEn, serialPortOneAct} <= 4'hF;
        e = '{4, OFF, OFF, OFF, OFF, DC, DC, DC, DC, DC, DC, DC};
        check("halt", W);
        @(posedge clock);
        cpuBoot <= 1'b1;
        e = '{4, 4, 4, DC, DC, DC, DC, DC, DC, DC, DC, DC};
        check("boot", W);
        unison(1, 0);
        unison(2, 0);
        @(posedge clock);
        cpuFault <= 1'b1;
        e = '{OFF, 8, 8, DC, DC, DC, DC, DC, DC, DC, DC, DC};
        check("cpu fault", 240);
        @(posedge clock);
        {cpuFault, cpuBoot, cpuHalt, serialPortOneAct} <= 4'h0;
        {serialPortTwoAct, netAvailable} <= 2'h1;
        net_case(6'h01, 264, 10, OFF, OFF);
        net_case(6'h02, W, 8, OFF, OFF);
        net_case(6'h04, W, 4, OFF, OFF);
        net_case(6'h08, W, 4, ON, 4);
        unison(7, 1);
        net_case(6'h20, W, 4, 4, 4);
        unison(6, 1);
        unison(7, 1);
        net_case(6'h03, W, 4, OFF, OFF);
        // an event is still logged from the traffic test: event lamp dark
        net_case(6'h10, W, ON, ON, OFF);
        results();
    end
endmodule

/* verilog/sic_code_flasher.sv */
`timescale 1ns/1ps
// flashes a two-digit code: high digit, short gap, low digit, long rest
module sic_code_flasher (
    input wire clock,
    input wire rstN,
    sic_code_if.flasher cif
);
    sic_pkg::sic_fl_state_t state_q;
    logic [4:0] cnt_q;      // half periods done in this phase
    logic lamp_q;
    // a zero digit shows one blink so it stays visible
    wire [3:0] hiDig = (cif.code[7:4] == 4'h0) ? 4'h1 : cif.code[7:4];
    wire [3:0] loDig = (cif.code[3:0] == 4'h0) ? 4'h1 : cif.code[3:0];
    wire [4:0] hiEnd = {hiDig, 1'b0};
    wire [4:0] loEnd = {loDig, 1'b0};
    wire [4:0] cntInc = cnt_q + 5'h01;
    // idle parks on the last rest half, so the first tick after run opens
    // the high digit lit and the first code shows every blink
    localparam logic [4:0] REST_LAST = 5'(sic_pkg::LONG_PAUSE_HALVES - 1);

    // phase sequencer, stepped once per half period
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            state_q <= sic_pkg::SIC_FL_REST;
            cnt_q <= REST_LAST;
            lamp_q <= 1'b0;
        end else if (!cif.run) begin
            state_q <= sic_pkg::SIC_FL_REST;
            cnt_q <= REST_LAST;
            lamp_q <= 1'b0;
        end else if (cif.tick) begin
            cnt_q <= cntInc;
            lamp_q <= 1'b0;
            case (state_q)
                sic_pkg::SIC_FL_HIGH: begin
                    lamp_q <= ~cntInc[0];
                    if (cntInc == hiEnd) begin
                        state_q <= sic_pkg::SIC_FL_GAP;
                        cnt_q <= 5'h00;
                        lamp_q <= 1'b0;
                    end
                end
                sic_pkg::SIC_FL_GAP: begin
                    if (cntInc == 5'(sic_pkg::SHORT_PAUSE_HALVES)) begin
                        state_q <= sic_pkg::SIC_FL_LOW;
                        cnt_q <= 5'h00;
                        lamp_q <= 1'b1;
                    end
                end
                sic_pkg::SIC_FL_LOW: begin
                    lamp_q <= ~cntInc[0];
                    if (cntInc == loEnd) begin
                        state_q <= sic_pkg::SIC_FL_REST;
                        cnt_q <= 5'h00;
                        lamp_q <= 1'b0;
                    end
                end
                default: begin
                    if (cntInc == 5'(sic_pkg::LONG_PAUSE_HALVES)) begin
                        state_q <= sic_pkg::SIC_FL_HIGH;
                        cnt_q <= 5'h00;
                        lamp_q <= 1'b1;
                    end
                end
            endcase
        end
    end
    assign cif.lamp = lamp_q;

    // lamp stays dark in both pauses
    a_pause_dark: assert property (@(posedge clock) disable iff (!rstN)
        (state_q == sic_pkg::SIC_FL_GAP || state_q == sic_pkg::SIC_FL_REST)
        |-> !lamp_q) else $error("flasher lit during pause");
    c_rest_reached: cover property (@(posedge clock) disable iff (!rstN)
        cif.run && state_q == sic_pkg::SIC_FL_REST);
endmodule

/* verilog/sic_status_lamps.sv */
`timescale 1ns/1ps
module sic_status_lamps #(
    parameter int unsigned SLOW_HALF = sic_pkg::SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = sic_pkg::FAST_HALF_CYC,
    parameter int unsigned FLASH_HALF = sic_pkg::FLASH_HALF_CYC,
    parameter int unsigned TRAFFIC_HOLD = sic_pkg::TRAFFIC_HOLD_CYC,
    parameter int NPORTS = 2
) (
    input wire clock,
    input wire nrst,
    // cpu state, from pins
    input wire cpuDiagPass,
    input wire cpuFault,
    input wire [7:0] cpuFaultCode,
    input wire cpuHalt,
    input wire cpuBoot,
    input wire cpuRun,
    input wire outScanEn,
    input wire serialPortOneAct,
    input wire serialPortTwoAct,
    // net interface state, one-hot code of sic_net_state_t
    input wire [5:0] netState,
    input wire [7:0] netFailCode,
    input wire netAvailable,
    input wire netTraffic,
    input wire eventLogged,
    // per-port phy status
    input wire [NPORTS-1:0] portLink,
    input wire [NPORTS-1:0] portTraffic,
    input wire [NPORTS-1:0] portFast,
    // lamps, high means lit
    output logic cpuHealthLamp,
    output logic runLamp,
    output logic outputs_enabled_lamp,
    output logic serial1_activity_lamp,
    output logic serial2_activity_lamp,
    output logic net_health_lamp,
    output logic net_availability_lamp,
    output logic netEventLamp,
    output logic [NPORTS-1:0] carrierLamp,
    output logic [NPORTS-1:0] speedLamp
);
    localparam int NIN = 17 + 3 * NPORTS;
    // reset release synchroniser
    logic [1:0] rstSync_q;
    wire rstN = rstSync_q[1];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) rstSync_q <= 2'h0;
        else rstSync_q <= {rstSync_q[0], 1'b1};
    end

    // all pin inputs pass two flops before use
    wire [NIN-1:0] rawIn = {cpuDiagPass, cpuFault, cpuHalt, cpuBoot, cpuRun,
        outScanEn, serialPortOneAct, serialPortTwoAct, netState,
        netAvailable, netTraffic, eventLogged, portLink, portTraffic,
        portFast};
    logic [NIN-1:0] syncA_q;
    logic [NIN-1:0] syncB_q;
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= rawIn;
            syncB_q <= syncA_q;
        end
    end
    // codes are quasi-static; double flopped likewise
    logic [15:0] codeA_q;
    logic [15:0] codeB_q;
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            codeA_q <= 16'h0000;
            codeB_q <= 16'h0000;
        end else begin
            codeA_q <= {cpuFaultCode, netFailCode};
            codeB_q <= codeA_q;
        end
    end

    // unpacked synchronised inputs
    wire sDiag = syncB_q[NIN-1];
    wire sFault = syncB_q[NIN-2];
    wire sHalt = syncB_q[NIN-3];
    wire sBoot = syncB_q[NIN-4];
    wire sRun = syncB_q[NIN-5];
    wire sScan = syncB_q[NIN-6];
    wire sSer1 = syncB_q[NIN-7];
    wire sSer2 = syncB_q[NIN-8];
    wire [5:0] sNet = syncB_q[NIN-9 -: 6];
    wire sAvail = syncB_q[3*NPORTS+2];
    wire sNetTr = syncB_q[3*NPORTS+1];
    wire sEvent = syncB_q[3*NPORTS];
    wire [NPORTS-1:0] sLink = syncB_q[3*NPORTS-1 -: NPORTS];
    wire [NPORTS-1:0] sPTr = syncB_q[2*NPORTS-1 -: NPORTS];
    wire [NPORTS-1:0] sFast = syncB_q[NPORTS-1:0];

    // slow and fast blink square waves
    logic [31:0] slowCnt_q;
    logic [31:0] fastCnt_q;
    logic [31:0] flashCnt_q;
    logic slow_q;
    logic fast_q;
    wire slowWrap = (slowCnt_q == SLOW_HALF - 1);
    wire fastWrap = (fastCnt_q == FAST_HALF - 1);
    wire flashWrap = (flashCnt_q == FLASH_HALF - 1);
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            slowCnt_q <= 32'h0;
            fastCnt_q <= 32'h0;
            flashCnt_q <= 32'h0;
            slow_q <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            slowCnt_q <= slowWrap ? 32'h0 : slowCnt_q + 32'h1;
            fastCnt_q <= fastWrap ? 32'h0 : fastCnt_q + 32'h1;
            flashCnt_q <= flashWrap ? 32'h0 : flashCnt_q + 32'h1;
            if (slowWrap) slow_q <= ~slow_q;
            if (fastWrap) fast_q <= ~fast_q;
        end
    end

    // activity stretchers: serial, net and port traffic
    localparam int NACT = 3 + NPORTS;
    wire [NACT-1:0] actIn = {sSer1, sSer2, sNetTr, sPTr};
    logic [NACT-1:0] actHeld;
    genvar g;
    generate
        for (g = 0; g < NACT; g++) begin : gAct
            logic [31:0] hold_q;
            always_ff @(posedge clock or negedge rstN) begin
                if (!rstN) hold_q <= 32'h0;
                else if (actIn[g]) hold_q <= TRAFFIC_HOLD;
                else if (hold_q != 32'h0) hold_q <= hold_q - 32'h1;
            end
            assign actHeld[g] = (hold_q != 32'h0);
        end
    endgenerate
    wire ser1Act = actHeld[NACT-1];
    wire ser2Act = actHeld[NACT-2];
    wire netAct = actHeld[NACT-3];
    wire [NPORTS-1:0] portAct = actHeld[NPORTS-1:0];

    // two code flashers: cpu code and net failure code
    sic_code_if cpuCif ();
    sic_code_if netCif ();
    assign cpuCif.code = codeB_q[15:8];
    assign cpuCif.run = sFault;
    assign cpuCif.tick = flashWrap;
    assign netCif.code = codeB_q[7:0];
    assign netCif.run = (sNet == sic_pkg::SIC_NET_HWFAIL);
    assign netCif.tick = flashWrap;
    sic_code_flasher uCpuFlash (.clock(clock), .rstN(rstN), .cif(cpuCif));
    sic_code_flasher uNetFlash (.clock(clock), .rstN(rstN), .cif(netCif));

    // cpu lamp decode, fault over boot over halt
    wire cpuOkD = sFault ? 1'b0 :
        sBoot ? slow_q :
        sHalt ? slow_q :
        sDiag;
    wire runD = sFault ? cpuCif.lamp :
        sBoot ? slow_q :
        sHalt ? 1'b0 : sRun;
    wire scanD = sFault ? cpuCif.lamp :
        sBoot ? slow_q :
        sHalt ? 1'b0 : sScan;
    wire ser1D = (sFault | sHalt) ? 1'b0 : ser1Act & fast_q;
    wire ser2D = (sFault | sHalt) ? 1'b0 : ser2Act & fast_q;

    // net lamp decode
    wire availD = !sAvail ? 1'b0 : netAct ? fast_q : 1'b1;
    logic netOkD;
    logic lanD;
    logic statD;
    always_comb begin
        netOkD = slow_q;
        lanD = 1'b0;
        statD = 1'b0;
        case (sNet)
            sic_pkg::SIC_NET_HWFAIL: netOkD = netCif.lamp;
            sic_pkg::SIC_NET_DIAG: netOkD = fast_q;
            sic_pkg::SIC_NET_WAITCFG: netOkD = slow_q;
            sic_pkg::SIC_NET_WAITIP: begin
                netOkD = slow_q;
                statD = slow_q;
                lanD = availD;
            end
            sic_pkg::SIC_NET_OPER: begin
                netOkD = 1'b1;
                lanD = availD;
                statD = !sEvent;
            end
            sic_pkg::SIC_NET_LOAD: begin
                lanD = slow_q;
                statD = slow_q;
            end
            default: netOkD = slow_q;
        endcase
    end
    // rate, duplex and crossover are sensed by the phy; lamps show result
    wire [NPORTS-1:0] carrD = sLink & ~(portAct & {NPORTS{fast_q}});
    wire [NPORTS-1:0] spdD = sLink & sFast;

    // all lamps registered
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            cpuHealthLamp <= 1'b0;
            runLamp <= 1'b0;
            outputs_enabled_lamp <= 1'b0;
            serial1_activity_lamp <= 1'b0;
            serial2_activity_lamp <= 1'b0;
            net_health_lamp <= 1'b0;
            net_availability_lamp <= 1'b0;
            netEventLamp <= 1'b0;
            carrierLamp <= '0;
            speedLamp <= '0;
        end else begin
            cpuHealthLamp <= cpuOkD;
            runLamp <= runD;
            outputs_enabled_lamp <= scanD;
            serial1_activity_lamp <= ser1D;
            serial2_activity_lamp <= ser2D;
            net_health_lamp <= netOkD;
            net_availability_lamp <= lanD;
            netEventLamp <= statD;
            carrierLamp <= carrD;
            speedLamp <= spdD;
        end
    end

    a_fault_dark: assert property (@(posedge clock) disable iff (!rstN)
        sFault |=> !cpuHealthLamp) else $error("health lit on fault");
    a_halt_others: assert property (@(posedge clock) disable iff (!rstN)
        (sHalt && !sFault && !sBoot) |=> (!runLamp && !outputs_enabled_lamp
        && cpuHealthLamp == $past(slow_q))) else $error("halt lamps");
    a_boot_unison: assert property (@(posedge clock) disable iff (!rstN)
        (sBoot && !sFault) |=> (runLamp == cpuHealthLamp &&
        outputs_enabled_lamp == cpuHealthLamp)) else $error("boot");
    a_run_follow: assert property (@(posedge clock) disable iff (!rstN)
        (!sFault && !sBoot && !sHalt) |=> (runLamp == $past(sRun) &&
        cpuHealthLamp == $past(sDiag))) else $error("run lamp");
    a_scan_follow: assert property (@(posedge clock) disable iff (!rstN)
        (!sFault && !sBoot && !sHalt) |=>
        outputs_enabled_lamp == $past(sScan)) else $error("scan lamp");
    a_speed_lamp: assert property (@(posedge clock) disable iff (!rstN)
        ##1 speedLamp == $past(sLink & sFast)) else $error("speed");
    a_carrier_off: assert property (@(posedge clock) disable iff (!rstN)
        ##1 (carrierLamp & ~$past(sLink)) == '0) else $error("carr");
    a_oper_health: assert property (@(posedge clock) disable iff (!rstN)
        (sNet == sic_pkg::SIC_NET_OPER) |=> net_health_lamp &&
        netEventLamp == !$past(sEvent)) else $error("oper net");
    a_load_unison: assert property (@(posedge clock) disable iff (!rstN)
        (sNet == sic_pkg::SIC_NET_LOAD) |=> (net_health_lamp ==
        net_availability_lamp && netEventLamp == net_health_lamp))
        else $error("load unison");
    a_cfg_dark: assert property (@(posedge clock) disable iff (!rstN)
        (sNet == sic_pkg::SIC_NET_WAITCFG || sNet == sic_pkg::SIC_NET_DIAG)
        |=> (!net_availability_lamp && !netEventLamp))
        else $error("cfg lamps");
    a_ip_unison: assert property (@(posedge clock) disable iff (!rstN)
        (sNet == sic_pkg::SIC_NET_WAITIP) |=> netEventLamp ==
        net_health_lamp) else $error("ip unison");
    a_avail_idle: assert property (@(posedge clock) disable iff (!rstN)
        (sNet == sic_pkg::SIC_NET_OPER && sAvail && !netAct) |=>
        net_availability_lamp) else $error("idle avail");
    c_boot: cover property (@(posedge clock) disable iff (!rstN)
        sBoot && cpuHealthLamp);
    c_hwfail: cover property (@(posedge clock) disable iff (!rstN)
        sNet == sic_pkg::SIC_NET_HWFAIL && net_health_lamp);
    c_traffic: cover property (@(posedge clock) disable iff (!rstN)
        carrierLamp[0] ##1 !carrierLamp[0]);
endmodule
